/* File: include/stm_defines.vh */
// register map, reset values and field positions of the sync timing measure block
// assumes an 8-bit register address and 8-bit register data
`ifndef STM_DEFINES_VH
`define STM_DEFINES_VH

`define STM_A_POLL       8'h32
`define STM_A_LPER_H     8'h40
`define STM_A_LPER_L     8'h41
`define STM_A_LWID_H     8'h42
`define STM_A_LWID_L     8'h43
`define STM_A_FPER_H     8'h44
`define STM_A_FPER_L     8'h45
`define STM_A_FWID       8'h46
`define STM_A_PSTART_H   8'h47
`define STM_A_PSTART_L   8'h48
`define STM_A_PCOUNT_H   8'h49
`define STM_A_PCOUNT_L   8'h4A
`define STM_A_LSTART_H   8'h4B
`define STM_A_LSTART_L   8'h4C
`define STM_A_LCOUNT_H   8'h4D
`define STM_A_LCOUNT_L   8'h4E
`define STM_A_MCFG       8'h4F

`define STM_RST_POLL     8'h00
`define STM_RST_PSTART_H 2'h0
`define STM_RST_PSTART_L 8'hF6
`define STM_RST_PCOUNT_H 4'h5
`define STM_RST_PCOUNT_L 8'h00
`define STM_RST_LSTART_H 2'h0
`define STM_RST_LSTART_L 8'h26
`define STM_RST_LCOUNT_H 4'h4
`define STM_RST_LCOUNT_L 8'h00
`define STM_RST_MCFG     1'h0

// poll control fields
`define STM_POLL_DIS_LO  0
`define STM_POLL_CONN_LO 4
// measurement config field
`define STM_MCFG_UNITS   0

// lines in one line-period window, and crystal clocks per coarse frame tick
`define STM_LINE_WINDOW  5'h10
`define STM_COARSE_DIV   10'h200

`endif

/* File: src/stm_sync_edge.v */
// two-flop synchroniser with edge detect for one sync pin
// assumes the pin is asynchronous to i_clk and active high
`timescale 1ns/1ps
module stm_sync_edge (
   input  wire i_clk,    // crystal clock
   input  wire i_rst_n,  // async reset, active low
   input  wire i_pin,    // raw sync pin
   output wire o_level,  // synchronised level
   output wire o_rise,   // leading edge pulse
   output wire o_fall    // trailing edge pulse
);
   reg meta_reg;
   reg sync_reg;
   reg prev_reg;

   // edge detect reads the second and third stages, never the first
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         meta_reg <= i_pin;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // edges in the same cycle as the synchronised level moves
   assign o_level = sync_reg;
   assign o_rise  = sync_reg & ~prev_reg;
   assign o_fall  = ~sync_reg & prev_reg;
endmodule

/* File: src/stm_active_window.v */
// active pixel gate generator from programmed start and size values
// assumes one pixel per clock and sync edges as single-cycle pulses
`timescale 1ns/1ps
module stm_active_window #(
   parameter HW = 12,  // pixel counter width
   parameter VW = 12   // line counter width
) (
   input  wire          i_clk,        // pixel clock
   input  wire          i_rst_n,      // async reset, active low
   input  wire          i_line_fall,  // line sync trailing edge
   input  wire          i_frame_fall, // frame sync trailing edge
   input  wire [9:0]    i_pix_start,  // clocks to first pixel
   input  wire [11:0]   i_pix_count,  // visible pixels
   input  wire [9:0]    i_line_start, // lines to first line
   input  wire [11:0]   i_line_count, // visible lines
   output reg           o_gate        // active pixel gate
);
   reg  [HW-1:0] hcnt_reg;
   reg  [VW-1:0] vcnt_reg;
   wire          h_on;
   wire          v_on;

   // counters restart on trailing sync edges and hold at their top
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hcnt_reg <= {HW{1'b0}};
         vcnt_reg <= {VW{1'b0}};
      end else begin
         if (i_line_fall)
            hcnt_reg <= {HW{1'b0}};
         else if (hcnt_reg != {HW{1'b1}})
            hcnt_reg <= hcnt_reg + 1'b1;
         if (i_frame_fall)
            vcnt_reg <= {VW{1'b0}};
         else if (i_line_fall && vcnt_reg != {VW{1'b1}})
            vcnt_reg <= vcnt_reg + 1'b1;
      end
   end

   // window: start inclusive, end exclusive; end sum one bit wider so a late window cannot wrap
   assign h_on = ({2'b00, i_pix_start} <= hcnt_reg) &&
                 ({1'b0, hcnt_reg} < {3'b000, i_pix_start} + {1'b0, i_pix_count});
   assign v_on = ({2'b00, i_line_start} <= vcnt_reg) &&
                 ({1'b0, vcnt_reg} < {3'b000, i_line_start} + {1'b0, i_line_count});

   // registered gate output
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         o_gate <= 1'b0;
      else
         o_gate <= h_on & v_on;
   end
endmodule

/* File: src/stm_measure.v */
// sync timing measurement, active window settings and sync polling controls
// assumes sync pins are asynchronous and active high, registers on a simple
// strobe port with read data one cycle after the read strobe
//
// Contract
// - Per channel, connector bit 0 polls line, composite and green sync, 1 polls green sync only.
// - Crystal clocks over sixteen line periods are reported as a 16-bit high/low pair.
// - The line period value holds one period with four fractional low bits.
// - Line sync high time summed over sixteen pulses is reported with four fractional bits.
// - A 12-bit frame period covers one whole frame.
// - Frame period equals high register times 256 plus low register.
// - Frame period and width are in lines or in crystal/512 periods per the units setting.
// - A 7-bit frame width counts only the true frame sync pulse.
// - A 10-bit pixel start count runs from line sync trailing edge, low byte default F6.
// - A 12-bit visible pixel count defaults to high 5, low 00.
// - A 10-bit line start count runs from frame sync trailing edge to the first line.
// - The line start count ends at the first valid line, low byte default 26.
// - A 12-bit visible line count bounds the active vertical window.
// - Units bit 0 reports frames in lines, 1 in 512-crystal-clock periods.
`timescale 1ns/1ps
`include "stm_defines.vh"
module stm_measure #(
   parameter CH = 3  // input channels
) (
   input  wire          i_clk,          // crystal clock, 20 MHz
   input  wire          i_rst_n,        // async reset, active low
   input  wire [7:0]    i_addr,         // register address
   input  wire [7:0]    i_wdata,        // register write data
   input  wire          i_wr,           // write strobe
   input  wire          i_rd,           // read strobe
   output reg  [7:0]    o_rdata,        // read data, cycle after strobe
   input  wire          i_line_sync,    // line sync pin, async
   input  wire          i_frame_sync,   // frame sync pin, async
   output wire          o_line_sync_output,  // synchronised line sync
   output wire          o_frame_sync_output, // synchronised frame sync
   output wire          o_active_pixel_gate, // active video gate
   output wire [CH-1:0] o_poll_enable,       // channel polling on
   output wire [CH-1:0] o_poll_line_sync,    // look for line sync
   output wire [CH-1:0] o_poll_composite_sync, // look for composite
   output wire [CH-1:0] o_poll_sync_on_green   // look for green sync
);
   // software settings
   reg  [7:0]  poll_reg;
   reg  [1:0]  pstart_h_reg;
   reg  [7:0]  pstart_l_reg;
   reg  [3:0]  pcount_h_reg;
   reg  [7:0]  pcount_l_reg;
   reg  [1:0]  lstart_h_reg;
   reg  [7:0]  lstart_l_reg;
   reg  [3:0]  lcount_h_reg;
   reg  [7:0]  lcount_l_reg;
   reg         units_reg;

   // measurement results, last completed
   reg  [15:0] lper_reg;
   reg  [15:0] lwid_reg;
   reg  [11:0] fper_reg;
   reg  [6:0]  fwid_reg;

   // running accumulators
   reg  [15:0] lper_acc_reg;
   reg  [15:0] lwid_acc_reg;
   reg  [4:0]  lper_n_reg;
   reg  [4:0]  lwid_n_reg;
   reg         lper_arm_reg;
   reg  [11:0] fper_acc_reg;
   reg  [6:0]  fwid_acc_reg;
   reg         fper_arm_reg;
   reg  [9:0]  div_reg;

   reg  [7:0]  rdata_next;

   wire        line_lvl;
   wire        line_rise;
   wire        line_fall;
   wire        frame_lvl;
   wire        frame_rise;
   wire        frame_fall;
   wire        coarse_tick;
   wire        frame_unit;

   // saturating increment helpers keep overflow from wrapping to small values
   function [15:0] stm_sat16;
      input [15:0] v;
      begin
         stm_sat16 = (v == 16'hFFFF) ? v : v + 16'h0001;
      end
   endfunction

   function [11:0] stm_sat12;
      input [11:0] v;
      begin
         stm_sat12 = (v == 12'hFFF) ? v : v + 12'h001;
      end
   endfunction

   // both sync pins pass two flops before any logic
   stm_sync_edge u_line_sync (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_pin   (i_line_sync),
      .o_level (line_lvl),
      .o_rise  (line_rise),
      .o_fall  (line_fall)
   );

   stm_sync_edge u_frame_sync (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_pin   (i_frame_sync),
      .o_level (frame_lvl),
      .o_rise  (frame_rise),
      .o_fall  (frame_fall)
   );

   assign o_line_sync_output  = line_lvl;
   assign o_frame_sync_output = frame_lvl;

   genvar g;
   generate
      for (g = 0; g < CH; g = g + 1) begin : g_poll
         assign o_poll_enable[g]         = ~poll_reg[`STM_POLL_DIS_LO + g];
         assign o_poll_line_sync[g]      = ~poll_reg[`STM_POLL_CONN_LO + g];
         assign o_poll_composite_sync[g] = ~poll_reg[`STM_POLL_CONN_LO + g];
         assign o_poll_sync_on_green[g]  = 1'b1;
      end
   endgenerate

   // register writes; measurement results have no write path
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         poll_reg     <= `STM_RST_POLL;
         pstart_h_reg <= `STM_RST_PSTART_H;
         pstart_l_reg <= `STM_RST_PSTART_L;
         pcount_h_reg <= `STM_RST_PCOUNT_H;
         pcount_l_reg <= `STM_RST_PCOUNT_L;
         lstart_h_reg <= `STM_RST_LSTART_H;
         lstart_l_reg <= `STM_RST_LSTART_L;
         lcount_h_reg <= `STM_RST_LCOUNT_H;
         lcount_l_reg <= `STM_RST_LCOUNT_L;
         units_reg    <= `STM_RST_MCFG;
      end else if (i_wr) begin
         if (i_addr == `STM_A_POLL)
            poll_reg <= i_wdata;
         else if (i_addr == `STM_A_PSTART_H)
            pstart_h_reg <= i_wdata[1:0];
         else if (i_addr == `STM_A_PSTART_L)
            pstart_l_reg <= i_wdata;
         else if (i_addr == `STM_A_PCOUNT_H)
            pcount_h_reg <= i_wdata[3:0];
         else if (i_addr == `STM_A_PCOUNT_L)
            pcount_l_reg <= i_wdata;
         else if (i_addr == `STM_A_LSTART_H)
            lstart_h_reg <= i_wdata[1:0];
         else if (i_addr == `STM_A_LSTART_L)
            lstart_l_reg <= i_wdata;
         else if (i_addr == `STM_A_LCOUNT_H)
            lcount_h_reg <= i_wdata[3:0];
         else if (i_addr == `STM_A_LCOUNT_L)
            lcount_l_reg <= i_wdata;
         else if (i_addr == `STM_A_MCFG)
            units_reg <= i_wdata[`STM_MCFG_UNITS];
      end
   end

   // coarse time base, one tick every 512 crystal clocks
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         div_reg <= 10'h000;
      else if (div_reg == `STM_COARSE_DIV - 10'h001)
         div_reg <= 10'h000;
      else
         div_reg <= div_reg + 10'h001;
   end
   assign coarse_tick = (div_reg == `STM_COARSE_DIV - 10'h001);

   // frame counting unit: line edges or coarse ticks
   assign frame_unit = units_reg ? coarse_tick : line_rise;

   // sixteen line periods, sum holds 1/16 clock resolution
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lper_acc_reg <= 16'h0000;
         lper_n_reg   <= 5'h00;
         lper_arm_reg <= 1'b0;
         lper_reg     <= 16'h0000;
      end else if (line_rise) begin
         lper_arm_reg <= 1'b1;
         lper_acc_reg <= 16'h0001;
         if (lper_arm_reg && lper_n_reg == `STM_LINE_WINDOW - 5'h01) begin
            // result replaced only when a window completes
            lper_reg   <= lper_acc_reg;
            lper_n_reg <= 5'h00;
         end else if (lper_arm_reg) begin
            lper_n_reg   <= lper_n_reg + 5'h01;
            lper_acc_reg <= stm_sat16(lper_acc_reg);
         end
      end else if (lper_arm_reg) begin
         lper_acc_reg <= stm_sat16(lper_acc_reg);
      end
   end

   // line sync high time summed over sixteen pulses
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lwid_acc_reg <= 16'h0000;
         lwid_n_reg   <= 5'h00;
         lwid_reg     <= 16'h0000;
      end else if (line_fall && lper_arm_reg) begin
         if (lwid_n_reg == `STM_LINE_WINDOW - 5'h01) begin
            lwid_reg     <= lwid_acc_reg;
            lwid_acc_reg <= 16'h0000;
            lwid_n_reg   <= 5'h00;
         end else begin
            lwid_n_reg <= lwid_n_reg + 5'h01;
         end
      end else if (line_lvl && (lper_arm_reg || line_rise)) begin
         // the arming pulse counts from its own leading edge, partial pulses never
         lwid_acc_reg <= stm_sat16(lwid_acc_reg);
      end
   end

   // frame period between frame sync leading edges
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fper_acc_reg <= 12'h000;
         fper_arm_reg <= 1'b0;
         fper_reg     <= 12'h000;
      end else if (frame_rise) begin
         fper_arm_reg <= 1'b1;
         fper_acc_reg <= 12'h000;
         if (fper_arm_reg)
            fper_reg <= fper_acc_reg;
      end else if (fper_arm_reg && frame_unit) begin
         fper_acc_reg <= stm_sat12(fper_acc_reg);
      end
   end

   // width from the frame sync level only, serrations never reach it
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fwid_acc_reg <= 7'h00;
         fwid_reg     <= 7'h00;
      end else if (frame_fall) begin
         fwid_reg     <= fwid_acc_reg;
         fwid_acc_reg <= 7'h00;
      end else if (frame_lvl && frame_unit && fwid_acc_reg != 7'h7F) begin
         fwid_acc_reg <= fwid_acc_reg + 7'h01;
      end
   end

   stm_active_window #(
      .HW (12),
      .VW (12)
   ) u_window (
      .i_clk        (i_clk),
      .i_rst_n      (i_rst_n),
      .i_line_fall  (line_fall),
      .i_frame_fall (frame_fall),
      .i_pix_start  ({pstart_h_reg, pstart_l_reg}),
      .i_pix_count  ({pcount_h_reg, pcount_l_reg}),
      .i_line_start ({lstart_h_reg, lstart_l_reg}),
      .i_line_count ({lcount_h_reg, lcount_l_reg}),
      .o_gate       (o_active_pixel_gate)
   );

   // read decode; unmapped addresses read zero
   always @* begin
      rdata_next = 8'h00;
      if (i_addr == `STM_A_POLL)
         rdata_next = poll_reg;
      // line period high then low byte
      else if (i_addr == `STM_A_LPER_H)
         rdata_next = lper_reg[15:8];
      else if (i_addr == `STM_A_LPER_L)
         rdata_next = lper_reg[7:0];
      else if (i_addr == `STM_A_LWID_H)
         rdata_next = lwid_reg[15:8];
      else if (i_addr == `STM_A_LWID_L)
         rdata_next = lwid_reg[7:0];
      // value is high times 256 plus low
      else if (i_addr == `STM_A_FPER_H)
         rdata_next = {4'h0, fper_reg[11:8]};
      else if (i_addr == `STM_A_FPER_L)
         rdata_next = fper_reg[7:0];
      else if (i_addr == `STM_A_FWID)
         rdata_next = {1'b0, fwid_reg};
      else if (i_addr == `STM_A_PSTART_H)
         rdata_next = {6'h00, pstart_h_reg};
      else if (i_addr == `STM_A_PSTART_L)
         rdata_next = pstart_l_reg;
      else if (i_addr == `STM_A_PCOUNT_H)
         rdata_next = {4'h0, pcount_h_reg};
      else if (i_addr == `STM_A_PCOUNT_L)
         rdata_next = pcount_l_reg;
      else if (i_addr == `STM_A_LSTART_H)
         rdata_next = {6'h00, lstart_h_reg};
      else if (i_addr == `STM_A_LSTART_L)
         rdata_next = lstart_l_reg;
      else if (i_addr == `STM_A_LCOUNT_H)
         rdata_next = {4'h0, lcount_h_reg};
      else if (i_addr == `STM_A_LCOUNT_L)
         rdata_next = lcount_l_reg;
      else if (i_addr == `STM_A_MCFG)
         rdata_next = {7'h00, units_reg};
   end

   // read data stands for one cycle only, zero otherwise
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         o_rdata <= 8'h00;
      else if (i_rd)
         o_rdata <= rdata_next;
      else
         o_rdata <= 8'h00;
   end
endmodule

/* File: dv/stm_props.sv */
// checker for register port, poll outputs and sync outputs of stm_measure
// assumes strobes come from a synchronous master and never overlap
`timescale 1ns/1ps
module stm_props #(
   parameter CH = 3  // input channels
) (
   input wire          i_clk,                 // crystal clock
   input wire          i_rst_n,               // async reset, active low
   input wire [7:0]    i_addr,                // register address
   input wire [7:0]    i_wdata,               // write data
   input wire          i_wr,                  // write strobe
   input wire          i_rd,                  // read strobe
   input wire [7:0]    o_rdata,               // read data
   input wire          i_line_sync,           // line sync pin
   input wire          i_frame_sync,          // frame sync pin
   input wire          o_line_sync_output,    // synchronised line sync
   input wire          o_frame_sync_output,   // synchronised frame sync
   input wire [CH-1:0] o_poll_enable,         // polling on
   input wire [CH-1:0] o_poll_line_sync,      // line sync polled
   input wire [CH-1:0] o_poll_composite_sync, // composite polled
   input wire [CH-1:0] o_poll_sync_on_green   // green sync polled
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   property p_poll_en;
      $past(i_wr && i_addr == 8'h32) |-> o_poll_enable == ~$past(i_wdata[CH-1:0]);
   endproperty
   a_poll_en: assert property (p_poll_en) else $error("poll enable differs from write");
   property p_poll_conn;
      $past(i_wr && i_addr == 8'h32) |-> o_poll_line_sync == ~$past(i_wdata[4 +: CH]);
   endproperty
   a_poll_conn: assert property (p_poll_conn) else $error("connector type not applied");
   property p_poll_comp;
      o_poll_composite_sync == o_poll_line_sync;
   endproperty
   a_poll_comp: assert property (p_poll_comp) else $error("composite poll differs");
   property p_poll_green;
      o_poll_sync_on_green == {CH{1'b1}};
   endproperty
   a_poll_green: assert property (p_poll_green) else $error("green sync not polled");
   property p_pstart;
      (i_wr && i_addr == 8'h48) ##1 (i_rd && i_addr == 8'h48) |=> o_rdata == $past(i_wdata, 2);
   endproperty
   a_pstart: assert property (p_pstart) else $error("pixel start readback wrong");
   property p_pcount;
      (i_wr && i_addr == 8'h49) ##1 (i_rd && i_addr == 8'h49) |=> o_rdata == {4'h0, $past(i_wdata[3:0], 2)};
   endproperty
   a_pcount: assert property (p_pcount) else $error("pixel count readback wrong");
   property p_lstart;
      (i_wr && i_addr == 8'h4B) ##1 (i_rd && i_addr == 8'h4B) |=> o_rdata == {6'h00, $past(i_wdata[1:0], 2)};
   endproperty
   a_lstart: assert property (p_lstart) else $error("line start readback wrong");
   property p_idle;
      !$past(i_rd) |-> o_rdata == 8'h00;
   endproperty
   a_idle: assert property (p_idle) else $error("read data outside read slot");
   property p_lsync;
      o_line_sync_output == $past(i_line_sync, 2);
   endproperty
   a_lsync: assert property (p_lsync) else $error("line sync delay wrong");
   property p_fsync;
      o_frame_sync_output == $past(i_frame_sync, 2);
   endproperty
   a_fsync: assert property (p_fsync) else $error("frame sync delay wrong");
endmodule

/* File: dv/stm_sync_src.sv */
// video source model making line and frame sync on the crystal clock grid
// assumes pins idle low until i_run, clean pulses with no serrations
`timescale 1ns/1ps
module stm_sync_src #(
   parameter LP  = 64,   // clocks per line
   parameter LW  = 8,    // line pulse clocks
   parameter LPF = 16,   // lines per frame
   parameter FO  = 32,   // frame pulse start, mid line
   parameter FW  = 192   // frame pulse clocks
) (
   input wire  i_clk,    // crystal clock
   input wire  i_rst_n,  // reset, active low
   input wire  i_run,    // start sync output
   output reg  o_line,   // line sync pin
   output reg  o_frame   // frame sync pin
);
   reg [15:0] pos_reg;
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n || !i_run) begin
         pos_reg <= 16'h0000;
         o_line  <= 1'b0;
         o_frame <= 1'b0;
      end else begin
         pos_reg <= (pos_reg == LP * LPF - 1) ? 16'h0000 : pos_reg + 16'h0001;
         o_line  <= (pos_reg % LP) < LW;
         o_frame <= pos_reg >= FO && pos_reg < FO + FW;
      end
   end
endmodule

/* File: dv/stm_measure_tb_top.sv */
// self-checking bench for stm_measure: registers, polling, sync measurement
// assumes the source model timing fixes every expected measurement
`timescale 1ns/1ps
module stm_measure_tb_top;
   localparam CH = 3;
   logic          clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, run = 1'b0;
   logic [7:0]    addr = 8'h00, wdata = 8'h00, q;
   wire  [7:0]    rdata;
   wire           lsync, fsync, lso, fso, gate;
   wire  [CH-1:0] pen, pls, pcs, pg;
   int            n_fail = 0, total_checks = 0;
   localparam logic [15:0] DEF [18] = '{16'h4700, 16'h48F6, 16'h4905, 16'h4A00, 16'h4B00, 16'h4C26,
      16'h4D04, 16'h4E00, 16'h4F00, 16'h3200, 16'h1000, 16'h4000, 16'h4100, 16'h4200, 16'h4300,
      16'h4400, 16'h4500, 16'h4600};
   localparam logic [15:0] MSK [8] = '{16'h4703, 16'h48FF, 16'h490F, 16'h4AFF, 16'h4B03, 16'h4CFF,
      16'h4D0F, 16'h4EFF};
   // 16 lines of 64 clocks per frame, pulse 8, frame pulse over 3 line starts
   localparam logic [15:0] MEAS [7] = '{16'h4004, 16'h4100, 16'h4200, 16'h4380, 16'h4400, 16'h4510,
      16'h4603};

   stm_measure #(.CH(CH)) stm_measure_i (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_line_sync(lsync), .i_frame_sync(fsync),
      .o_line_sync_output(lso), .o_frame_sync_output(fso), .o_active_pixel_gate(gate),
      .o_poll_enable(pen), .o_poll_line_sync(pls), .o_poll_composite_sync(pcs), .o_poll_sync_on_green(pg));
   stm_sync_src stm_sync_src_i (.i_clk(clk), .i_rst_n(rst_n), .i_run(run), .o_line(lsync), .o_frame(fsync));

   // free-running crystal clock, 50 ns
   initial begin
      forever #25 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] r);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 r = rdata;
   endtask
   // write then read with no gap between the strobes
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 r = rdata;
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic t_defaults;
      foreach (DEF[i]) begin
         rd_reg(DEF[i][15:8], q);
         chk("reset value", {8'h00, q}, {8'h00, DEF[i][7:0]});
      end
      $display("test defaults done");
   endtask
   task automatic t_rw;
      foreach (MSK[i]) begin
         wr_rd(MSK[i][15:8], 8'hA5, q);
         chk("readback a5", {8'h00, q}, {8'h00, 8'hA5 & MSK[i][7:0]});
         wr_rd(MSK[i][15:8], 8'h5A, q);
         chk("readback 5a", {8'h00, q}, {8'h00, 8'h5A & MSK[i][7:0]});
      end
      $display("test rw done");
   endtask
   task automatic t_poll;
      logic [7:0] d;
      for (int c = 0; c < 8; c++) begin
         d = {1'b0, c[2:0], 1'b1, c[2:0] ^ 3'h5};
         wr_reg(8'h32, d);
         #1 chk("poll enable", {13'h0, pen}, {13'h0, ~(c[2:0] ^ 3'h5)});
         chk("poll line", {13'h0, pls}, {13'h0, ~c[2:0]});
         chk("poll composite", {13'h0, pcs}, {13'h0, ~c[2:0]});
         chk("poll green", {13'h0, pg}, 16'h0007);
         rd_reg(8'h32, q);
         chk("poll readback", {8'h00, q & 8'h77}, {8'h00, d & 8'h77});
      end
      wr_reg(8'h32, 8'h08);
      $display("test poll done");
   endtask
   task automatic t_meas;
      @(posedge clk);
      run <= 1'b1;
      repeat (6 * 1024) @(posedge clk);
      // second pass tries to overwrite each result first
      for (int p = 0; p < 2; p++) begin
         foreach (MEAS[i]) begin
            if (p == 1) wr_reg(MEAS[i][15:8], 8'hFF);
            rd_reg(MEAS[i][15:8], q);
            chk("measurement", {8'h00, q}, {8'h00, MEAS[i][7:0]});
         end
      end
      wr_reg(8'h4F, 8'h01);
      repeat (4 * 1024) @(posedge clk);
      rd_reg(8'h44, q);
      chk("frame period high ticks", {8'h00, q}, 16'h0000);
      rd_reg(8'h45, q);
      chk("frame period low ticks", {8'h00, q}, 16'h0002);
      rd_reg(8'h40, q);
      chk("line period kept", {8'h00, q}, 16'h0004);
      $display("test measure done");
   endtask
   // small window: lines 1 to 4, pixels 4 to 11, so every frame holds 4 x 8 gate cycles
   task automatic t_gate;
      int gcnt;
      gcnt = 0;
      wr_reg(8'h47, 8'h00);
      wr_reg(8'h48, 8'h04);
      wr_reg(8'h49, 8'h00);
      wr_reg(8'h4A, 8'h08);
      wr_reg(8'h4B, 8'h00);
      wr_reg(8'h4C, 8'h01);
      wr_reg(8'h4D, 8'h00);
      wr_reg(8'h4E, 8'h04);
      repeat (4) @(posedge clk);
      repeat (1024) begin
         @(posedge clk);
         #1 if (gate === 1'b1) gcnt++;
      end
      chk("gate cycles per frame", gcnt[15:0], 16'h0020);
      $display("test gate done");
   endtask

   // main sequence after 12 reset cycles
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_defaults();
      t_rw();
      t_poll();
      t_meas();
      t_gate();
      summarize();
   end
   // watchdog well past the expected run of about 11500 cycles
   initial begin
      repeat (30000) @(posedge clk);
      n_fail++;
      summarize();
   end
endmodule

bind stm_measure stm_props #(.CH(CH)) stm_props_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_line_sync(i_line_sync),
   .i_frame_sync(i_frame_sync), .o_line_sync_output(o_line_sync_output),
   .o_frame_sync_output(o_frame_sync_output), .o_poll_enable(o_poll_enable),
   .o_poll_line_sync(o_poll_line_sync), .o_poll_composite_sync(o_poll_composite_sync),
   .o_poll_sync_on_green(o_poll_sync_on_green));
